// *** rtl/axh_defs.vh ***
`ifndef AXH_DEFS_VH
`define AXH_DEFS_VH
// Register byte offsets
`define AXH_ADDR_CTRL        8'h00
`define AXH_ADDR_ZERO_OFFSET 8'h04
`define AXH_ADDR_SPEED_FAST  8'h08
`define AXH_ADDR_SPEED_SLOW  8'h0C
`define AXH_ADDR_STATUS      8'h10
`define AXH_ADDR_IRQ_STATUS  8'h14
`define AXH_ADDR_IRQ_MASK    8'h18
// Control register fields
`define AXH_CTRL_COND_LSB    0
`define AXH_CTRL_COND_MSB    1
`define AXH_CTRL_INF_BIT     2
`define AXH_CTRL_TYPE_LSB    8
`define AXH_CTRL_TYPE_MSB    15
`define AXH_CTRL_START_BIT   16
`define AXH_CTRL_DCLR_BIT    17
// Start conditions
`define AXH_COND_OFF         2'h0
`define AXH_COND_AUTO        2'h1
`define AXH_COND_START_ON_FIRST_TABLE_SET        2'h2
// Homing types, two's complement byte
`define AXH_TYPE_M4          8'hFC
`define AXH_TYPE_M3          8'hFD
`define AXH_TYPE_M2          8'hFE
`define AXH_TYPE_M1          8'hFF
`define AXH_TYPE_ZERO        8'h00
`define AXH_TYPE_1           8'h01
`define AXH_TYPE_MIN         (-4)
`define AXH_TYPE_MAX         35
// Reset values
`define AXH_RST_TYPE         8'hFF
`define AXH_RST_SPEED        32'h0000_0014
// Interrupt bits
`define AXH_IRQ_DONE         0
`define AXH_IRQ_ERR          1
`define AXH_IRQ_REREF        2
`endif

// *** rtl/axh_homing_sequencer.v ***
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "axh_defs.vh"
// What this block does
// - Condition 0: start on every request
// - Condition 1: reference once at first control start
// - Condition 2: reference once at first set selection
// - Reference events from negative limit, cam, zero pulse
// - Type -1: position becomes zero offset
// - Type -2: no run, position untouched
// - Type -3: type 20 run, then continuous
// - Type -4: type 22 run, then continuous
// - Types -3/-4 need infinite travel on
// - Continuous: cam rising edge loads zero offset
// - Continuous load also corrects remaining travel
// - Type 1: seek negative limit, reverse on edge
// - Type 1: zero at first pulse after fall
// - Quick speed until first event, then slow
// - Types -4 to 35 accepted, default -1
module axh_homing_sequencer (
  input  wire        sys_clk_i,
  input  wire        srst_i,
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire        lim_neg_i,
  input  wire        lim_pos_i,
  input  wire        ref_cam_i,
  input  wire        zero_pulse_i,
  input  wire        field_bus_homing_i,
  input  wire        terminal_homing_request_i,
  input  wire        plc_start_i,
  input  wire        loop_control_start_i,
  input  wire        table_set_select_i,
  input  wire [31:0] pos_actual_i,
  output reg         move_en_o,
  output reg         move_dir_o,
  output reg  [31:0] speed_o,
  output reg         pos_set_o,
  output reg  [31:0] pos_set_value_o,
  output reg         remain_corr_o,
  output reg  [31:0] remain_corr_delta_o,
  output reg         irq_o
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SEEK  = 3'h1;
  localparam [2:0] ST_BACK  = 3'h2;
  localparam [2:0] ST_ZERO  = 3'h3;
  localparam [2:0] ST_CAMIN = 3'h4;
  localparam [2:0] ST_CAMOUT = 3'h5;
  localparam [2:0] ST_CAMRE = 3'h6;
  reg [1:0]  start_cond;
  reg        inf_travel;
  reg [7:0]  type_sel;
  reg [31:0] zero_offset;
  reg [31:0] speed_fast;
  reg [31:0] speed_slow;
  reg [2:0]  irq_stat;
  reg [2:0]  irq_mask;
  reg        done;
  reg        cfg_err;
  reg        cont_active;
  reg [2:0]  state;
  reg        cam_dir;
  reg        sw_start;
  reg        ph_wr;
  reg [7:0]  ph_addr;
  reg        lim_neg_q, cam_q, fb_q, term_q, plc_q, loop_q, tbl_q;
  reg [2:0]  ev;
  reg [31:0] next_rdata;
  wire       acc_ok = hsel_i && htrans_i[1] && hready_i;
  wire       wr_ctrl = ph_wr && (ph_addr == `AXH_ADDR_CTRL);
  wire       lim_neg_rise = lim_neg_i && !lim_neg_q;
  wire       lim_neg_fall = !lim_neg_i && lim_neg_q;
  wire       cam_rise = ref_cam_i && !cam_q;
  wire       cam_fall = !ref_cam_i && cam_q;
  wire       manual_req = (field_bus_homing_i && !fb_q) || (terminal_homing_request_i && !term_q) ||
                          (plc_start_i && !plc_q);
  wire       loop_rise = loop_control_start_i && !loop_q;
  wire       tbl_rise = table_set_select_i && !tbl_q;
  reg        start_req;
  // Signed range test on a homing type byte
  function type_ok;
    input [7:0] t;
    begin
      type_ok = ($signed(t) >= `AXH_TYPE_MIN) && ($signed(t) <= `AXH_TYPE_MAX);
    end
  endfunction
  // Types the sequencer can actually run; the rest report an error
  function type_runnable;
    input [7:0] t;
    input       inf;
    begin
      case (t)
        `AXH_TYPE_M1, `AXH_TYPE_M2, `AXH_TYPE_1: type_runnable = 1'b1;
        `AXH_TYPE_M3, `AXH_TYPE_M4:             type_runnable = inf;
        default:                                 type_runnable = 1'b0;
      endcase
    end
  endfunction
  // Start selection by condition
  always @* begin
    start_req = sw_start;
    case (start_cond)
      `AXH_COND_OFF:  start_req = start_req || manual_req;
      `AXH_COND_AUTO: start_req = start_req || (loop_rise && !done);
      `AXH_COND_START_ON_FIRST_TABLE_SET: start_req = start_req || (tbl_rise && !done);
      default:        start_req = sw_start;
    endcase
  end
  // Edge history of the negative limit, cam and start request inputs
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      lim_neg_q <= 1'b0;
      cam_q     <= 1'b0;
      fb_q      <= 1'b0;
      term_q    <= 1'b0;
      plc_q     <= 1'b0;
      loop_q    <= 1'b0;
      tbl_q     <= 1'b0;
    end else begin
      lim_neg_q <= lim_neg_i;
      cam_q     <= ref_cam_i;
      fb_q      <= field_bus_homing_i;
      term_q    <= terminal_homing_request_i;
      plc_q     <= plc_start_i;
      loop_q    <= loop_control_start_i;
      tbl_q     <= table_set_select_i;
    end
  end
  // Read mux, registered so data stands in the data phase with no wait
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr_i)
      `AXH_ADDR_CTRL: begin
        next_rdata[`AXH_CTRL_COND_MSB:`AXH_CTRL_COND_LSB] = start_cond;
        next_rdata[`AXH_CTRL_INF_BIT] = inf_travel;
        next_rdata[`AXH_CTRL_TYPE_MSB:`AXH_CTRL_TYPE_LSB] = type_sel;
      end
      `AXH_ADDR_ZERO_OFFSET: next_rdata = zero_offset;
      `AXH_ADDR_SPEED_FAST:  next_rdata = speed_fast;
      `AXH_ADDR_SPEED_SLOW:  next_rdata = speed_slow;
      `AXH_ADDR_STATUS:      next_rdata = {24'h00_0000, lim_pos_i, state, cont_active, cfg_err,
                                           (state != ST_IDLE), done};
      `AXH_ADDR_IRQ_STATUS:  next_rdata = {29'h0000_0000, irq_stat};
      `AXH_ADDR_IRQ_MASK:    next_rdata = {29'h0000_0000, irq_mask};
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: address phase capture, write in data phase
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      ph_wr       <= 1'b0;
      ph_addr     <= 8'h00;
      start_cond  <= `AXH_COND_OFF;
      inf_travel  <= 1'b0;
      type_sel    <= `AXH_RST_TYPE;
      zero_offset <= 32'h0000_0000;
      speed_fast  <= `AXH_RST_SPEED;
      speed_slow  <= `AXH_RST_SPEED;
      irq_mask    <= 3'h0;
      sw_start    <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      ph_wr       <= acc_ok && hwrite_i;
      ph_addr     <= haddr_i;
      sw_start    <= 1'b0;
      if (acc_ok && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
      if (wr_ctrl) begin
        start_cond <= hwdata_i[`AXH_CTRL_COND_MSB:`AXH_CTRL_COND_LSB];
        inf_travel <= hwdata_i[`AXH_CTRL_INF_BIT];
        // Out-of-range types are dropped, the old type stays
        if (type_ok(hwdata_i[`AXH_CTRL_TYPE_MSB:`AXH_CTRL_TYPE_LSB])) begin
          type_sel <= hwdata_i[`AXH_CTRL_TYPE_MSB:`AXH_CTRL_TYPE_LSB];
        end
        sw_start <= hwdata_i[`AXH_CTRL_START_BIT];
      end
      if (ph_wr && ph_addr == `AXH_ADDR_ZERO_OFFSET) zero_offset <= hwdata_i;
      if (ph_wr && ph_addr == `AXH_ADDR_SPEED_FAST) speed_fast <= hwdata_i;
      if (ph_wr && ph_addr == `AXH_ADDR_SPEED_SLOW) speed_slow <= hwdata_i;
      if (ph_wr && ph_addr == `AXH_ADDR_IRQ_MASK) irq_mask <= hwdata_i[2:0];
    end
  end

  // Sequencer: a run may only start from idle, later requests are ignored
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state           <= ST_IDLE;
      cam_dir         <= 1'b1;
      done            <= 1'b0;
      cfg_err         <= 1'b0;
      cont_active     <= 1'b0;
      move_en_o       <= 1'b0;
      move_dir_o      <= 1'b0;
      speed_o         <= 32'h0000_0000;
      pos_set_o       <= 1'b0;
      pos_set_value_o <= 32'h0000_0000;
      remain_corr_o   <= 1'b0;
      remain_corr_delta_o <= 32'h0000_0000;
      ev              <= 3'h0;
    end else begin
      pos_set_o     <= 1'b0;
      remain_corr_o <= 1'b0;
      ev            <= 3'h0;
      if (wr_ctrl && hwdata_i[`AXH_CTRL_DCLR_BIT]) done <= 1'b0;
      case (state)
        ST_IDLE: begin
          move_en_o <= 1'b0;
          // Correction only once a continuous run has completed
          if (cont_active && cam_rise) begin
            pos_set_o           <= 1'b1;
            pos_set_value_o     <= zero_offset;
            remain_corr_o       <= 1'b1;
            remain_corr_delta_o <= zero_offset - pos_actual_i;
            ev[`AXH_IRQ_REREF]  <= 1'b1;
          end
          if (start_req) begin
            cont_active <= 1'b0;
            if (!type_runnable(type_sel, inf_travel)) begin
              cfg_err           <= 1'b1;
              ev[`AXH_IRQ_ERR]  <= 1'b1;
            end else begin
              cfg_err <= 1'b0;
              case (type_sel)
                `AXH_TYPE_M1: begin
                  pos_set_o         <= 1'b1;
                  pos_set_value_o   <= 32'h0000_0000 + zero_offset;
                  done              <= 1'b1;
                  ev[`AXH_IRQ_DONE] <= 1'b1;
                end
                `AXH_TYPE_M2: begin
                  done              <= 1'b1;
                  ev[`AXH_IRQ_DONE] <= 1'b1;
                end
                `AXH_TYPE_1: begin
                  state      <= lim_neg_i ? ST_BACK : ST_SEEK;
                  move_en_o  <= 1'b1;
                  move_dir_o <= lim_neg_i;
                  speed_o    <= lim_neg_i ? speed_slow : speed_fast;
                end
                default: begin
                  // Type 20 seeks the cam forward, type 22 backward
                  cam_dir    <= (type_sel == `AXH_TYPE_M3);
                  state      <= ST_CAMIN;
                  move_en_o  <= 1'b1;
                  move_dir_o <= (type_sel == `AXH_TYPE_M3);
                  speed_o    <= speed_fast;
                end
              endcase
            end
          end
        end
        ST_SEEK: begin
          if (lim_neg_rise) begin
            state      <= ST_BACK;
            move_dir_o <= 1'b1;
            speed_o    <= speed_slow;
          end
        end
        ST_BACK: begin
          if (lim_neg_fall) state <= ST_ZERO;
        end
        ST_ZERO: begin
          if (zero_pulse_i) begin
            state             <= ST_IDLE;
            move_en_o         <= 1'b0;
            pos_set_o         <= 1'b1;
            pos_set_value_o   <= zero_offset;
            done              <= 1'b1;
            ev[`AXH_IRQ_DONE] <= 1'b1;
          end
        end
        ST_CAMIN: begin
          if (ref_cam_i) begin
            state      <= ST_CAMOUT;
            move_dir_o <= !cam_dir;
            speed_o    <= speed_slow;
          end
        end
        ST_CAMOUT: begin
          if (cam_fall) begin
            state      <= ST_CAMRE;
            move_dir_o <= cam_dir;
          end
        end
        ST_CAMRE: begin
          // Zero point is the slow rising edge of the cam
          if (cam_rise) begin
            state             <= ST_IDLE;
            move_en_o         <= 1'b0;
            pos_set_o         <= 1'b1;
            pos_set_value_o   <= zero_offset;
            done              <= 1'b1;
            cont_active       <= 1'b1;
            ev[`AXH_IRQ_DONE] <= 1'b1;
          end
        end
        default: begin
          state     <= ST_IDLE;
          move_en_o <= 1'b0;
        end
      endcase
    end
  end

  // Sticky interrupt flags; a new event beats a same-cycle clear
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_stat <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      if (ph_wr && ph_addr == `AXH_ADDR_IRQ_STATUS) begin
        irq_stat <= (irq_stat & ~hwdata_i[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end
endmodule
`default_nettype wire

// *** testbench/axh_axis_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module axh_axis_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        move_en_i,
  input  wire logic        move_dir_i,
  input  wire logic        jog_i,
  input  wire logic        pos_set_i,
  input  wire logic [31:0] pos_set_value_i,
  output wire logic        lim_neg_o,
  output wire logic        lim_pos_o,
  output wire logic        ref_cam_o,
  output wire logic        zero_pulse_o,
  output var  logic [31:0] pos_o
);
  // One count a cycle; speed is the drive's concern, not the switches'
  always @(posedge clk_i) begin
    if (srst_i) begin
      pos_o <= 32'h0000_0000;
    end else if (pos_set_i) begin
      pos_o <= pos_set_value_i;
    end else if (move_en_i | jog_i) begin
      pos_o <= (move_dir_i | ~move_en_i) ? pos_o + 32'h0000_0001 : pos_o - 32'h0000_0001;
    end
  end
  // Limits far apart so one run never meets both of them
  assign lim_neg_o    = $signed(pos_o) < -100;
  assign lim_pos_o    = $signed(pos_o) > 1000;
  // Cam repeats every 64 counts, one rotation; no lag, so no lag limit to exceed
  assign ref_cam_o    = pos_o[5:3] == 3'h5;
  assign zero_pulse_o = pos_o[3:0] == 4'h0;
endmodule
`default_nettype wire

// *** testbench/axh_homing_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module axh_homing_checker (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic lim_neg_i,
  input wire logic ref_cam_i,
  input wire logic move_en_o,
  input wire logic move_dir_o,
  input wire logic pos_set_o,
  input wire logic remain_corr_o
);
  logic [3:0] ev_hist;
  logic       lim_q;
  logic       cam_q;
  // Recent switch edges; a direction flip needs one of them as cause
  always @(posedge sys_clk_i) begin
    lim_q   <= lim_neg_i;
    cam_q   <= ref_cam_i;
    ev_hist <= srst_i ? 4'h0 : {ev_hist[2:0], (lim_q ^ lim_neg_i) | (cam_q ^ ref_cam_i)};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  bus_okay_a: assert property (!hresp_o) else $error("bus response not okay");
  ready_up_a: assert property (!$past(srst_i) |-> hreadyout_o) else $error("bus stalled");
  set_pulse_a: assert property (pos_set_o |=> !pos_set_o) else $error("position load too long");
  corr_pair_a: assert property (remain_corr_o |-> ##[0:1] pos_set_o) else $error("correction alone");
  corr_cam_a: assert property (remain_corr_o |-> ref_cam_i && !move_en_o) else $error("correction w/o cam");
  set_stop_a: assert property (pos_set_o && $past(move_en_o) |-> ##[0:1] !move_en_o) else $error("no stop");
  lim_turn_a: assert property ($rose(lim_neg_i) && move_en_o && !move_dir_o
    |-> ##[1:3] move_en_o && move_dir_o) else $error("no reversal at limit");
  dir_cause_a: assert property (move_en_o && $past(move_en_o) && $changed(move_dir_o) |-> |ev_hist)
    else $error("turn without event");
  cover property (remain_corr_o);
  cover property ($rose(lim_neg_i) && move_en_o);
  cover property (pos_set_o && !move_en_o);
endmodule
bind axh_homing_sequencer axh_homing_checker u_axh_homing_checker (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .lim_neg_i(lim_neg_i), .ref_cam_i(ref_cam_i), .move_en_o(move_en_o), .move_dir_o(move_dir_o),
  .pos_set_o(pos_set_o), .remain_corr_o(remain_corr_o));
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "axh_defs.vh"
module tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hw = 1'b0;
  logic        jog = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [4:0]  req = 5'h00;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwd = 32'h0000_0000;
  logic [31:0] rd;
  wire  [31:0] hrd, pos, spd, pv, rcd;
  wire         rdy, ln, lp, cam, zp, men, dir, ps, rc, irq;
  int          failures = 0;
  int          compares = 0;
  int          ns, nm, n;
  always #25 clk = ~clk;
  axh_homing_sequencer u_axh_homing_sequencer (
    .sys_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd),
    .hreadyout_o(rdy), .hresp_o(), .lim_neg_i(ln), .lim_pos_i(lp), .ref_cam_i(cam),
    .zero_pulse_i(zp), .field_bus_homing_i(req[0]), .terminal_homing_request_i(req[1]),
    .plc_start_i(req[2]), .loop_control_start_i(req[3]), .table_set_select_i(req[4]),
    .pos_actual_i(pos), .move_en_o(men), .move_dir_o(dir), .speed_o(spd), .pos_set_o(ps),
    .pos_set_value_o(pv), .remain_corr_o(rc), .remain_corr_delta_o(rcd), .irq_o(irq));
  axh_axis_model u_axh_axis_model (
    .clk_i(clk), .srst_i(srst), .move_en_i(men), .move_dir_i(dir), .jog_i(jog),
    .pos_set_i(ps), .pos_set_value_i(pv), .lim_neg_o(ln), .lim_pos_o(lp),
    .ref_cam_o(cam), .zero_pulse_o(zp), .pos_o(pos));
  task automatic conclude;
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // A bounded wait that ran out ends the run
  task automatic need(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      conclude;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic rdy_wait;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rdy === 1'b1) return;
    end
    need(1'b0);
  endtask
  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hw <= w;
    rdy_wait;
    htrans <= 2'h0;
    hwd <= d;
    rdy_wait;
    rd = hrd;
  endtask
  // Samples are the values settled before each edge
  task automatic watch(input int k);
    ns = 0;
    nm = 0;
    repeat (k) begin
      @(posedge clk);
      ns += (ps === 1'b1);
      nm += (men === 1'b1);
    end
  endtask
  task automatic s_reset;
    bus(0, `AXH_ADDR_SPEED_FAST, 0);
    chk(rd, `AXH_RST_SPEED);
    bus(0, 8'h1C, 0);
    chk(rd, 0);
    bus(1, `AXH_ADDR_CTRL, 32'h0000_2400);
    bus(0, `AXH_ADDR_CTRL, 0);
    chk(rd[15:8], `AXH_RST_TYPE);
    bus(0, `AXH_ADDR_STATUS, 0);
    chk(rd, 0);
  endtask
  task automatic s_neg(input logic [7:0] t, input logic [31:0] o, input logic [31:0] p);
    bus(1, `AXH_ADDR_ZERO_OFFSET, o);
    bus(1, `AXH_ADDR_CTRL, {16'h0003, t, 8'h00});
    watch(6);
    chk(ns + nm, t[0]);
    chk(pos, p);
    bus(0, `AXH_ADDR_STATUS, 0);
    chk(rd[0], 1'b1);
  endtask
  task automatic s_cfg(input logic [7:0] t);
    bus(1, `AXH_ADDR_CTRL, {16'h0001, t, 8'h00});
    watch(6);
    chk(ns + nm, 0);
    bus(0, `AXH_ADDR_STATUS, 0);
    chk(rd[2], 1'b1);
  endtask
  task automatic s_type1;
    int z;
    z = 0;
    bus(1, `AXH_ADDR_SPEED_FAST, 32'h0000_0007);
    bus(1, `AXH_ADDR_SPEED_SLOW, 32'h0000_0003);
    bus(1, `AXH_ADDR_ZERO_OFFSET, 32'h0000_000B);
    bus(1, `AXH_ADDR_CTRL, 32'h0001_0100);
    for (n = 0; n < 400 && ps !== 1'b1; n++) begin
      @(posedge clk);
      if (men === 1'b1) chk(spd, dir ? 32'h0000_0003 : 32'h0000_0007);
      z += (men === 1'b1 && dir === 1'b1 && zp === 1'b1);
    end
    need(ps);
    chk(z, 1);
    tick(2);
    chk(pos, 32'h0000_000B);
  endtask
  // Level request held high: only its rising edge counts
  task automatic s_start(input logic [1:0] c, input int b);
    bus(1, `AXH_ADDR_CTRL, {14'h0000, 2'h2, 8'hFF, 6'h00, c});
    for (int i = 1; i >= 0; i--) begin
      req[b] <= 1'b1;
      watch(8);
      chk(ns, (i == 1) || (c == 2'h0));
      req[b] <= 1'b0;
      tick(2);
    end
  endtask
  task automatic s_cont(input logic [7:0] t);
    bus(1, `AXH_ADDR_IRQ_STATUS, 32'h0000_0007);
    bus(1, `AXH_ADDR_ZERO_OFFSET, 32'h0000_0003);
    bus(1, `AXH_ADDR_IRQ_MASK, 32'h0000_0004);
    bus(1, `AXH_ADDR_CTRL, {16'h0001, t, 8'h04});
    watch(300);
    chk(ns, 1);
    bus(0, `AXH_ADDR_STATUS, 0);
    chk(rd[3], 1'b1);
    jog <= 1'b1;
    for (n = 0; n < 100 && rc !== 1'b1; n++) @(posedge clk);
    need(rc);
    chk(rcd, 32'hFFFF_FFDB);
    tick(2);
    chk(irq, 1'b1);
    bus(1, `AXH_ADDR_IRQ_STATUS, 32'h0000_0004);
    tick(2);
    chk(irq, 1'b0);
    bus(1, `AXH_ADDR_IRQ_MASK, 32'h0000_0000);
    watch(60);
    chk(ns + irq, 1);
    bus(0, `AXH_ADDR_IRQ_STATUS, 0);
    chk(rd[2], 1'b1);
    jog <= 1'b0;
  endtask
  initial begin
    tick(5);
    srst <= 1'b0;
    tick(1);
    s_reset;
    s_neg(`AXH_TYPE_M1, 32'h0000_0005, 32'h0000_0005);
    s_neg(`AXH_TYPE_M2, 32'h0000_0009, 32'h0000_0005);
    s_cfg(`AXH_TYPE_ZERO);
    s_cfg(`AXH_TYPE_M3);
    s_type1;
    for (int i = 0; i < 3; i++) s_start(2'h0, i);
    s_start(2'h1, 3);
    s_start(2'h2, 4);
    s_cont(`AXH_TYPE_M3);
    s_cont(`AXH_TYPE_M4);
    conclude;
  end
endmodule
`default_nettype wire
